// ==== fdm_params.svh ====
/*
 * Register offsets, control field layout and reset values of the
 * multiply-add block's software port.
 * Assumes byte offsets on a 4-bit address, one 32-bit word per register.
 */
`ifndef FDM_PARAMS_SVH
`define FDM_PARAMS_SVH

// register offsets
`define FDM_OFS_CTRL 4'h0
`define FDM_OFS_RES_LO 4'h4
`define FDM_OFS_RES_HI 4'h8
`define FDM_OFS_CMD 4'hC

// control word: width and reset value
`define FDM_CTRL_W 10
`define FDM_CTRL_RST 10'h000

// command word: bit that clears the result / accumulator
`define FDM_CMD_CLR_BIT 0

// datapath widths
`define FDM_RES_W 48
`define FDM_A_W 19
`define FDM_B_W 18

`endif

// ==== fdm_pkg.sv ====
/*
 * Types shared by the multiply-add block: mode and operation
 * enumerations, the control word and the operand bundle.
 * Assumes fdm_params.svh is on the include path.
 */
`include "fdm_params.svh"

package fdm_pkg;

	// partitioning modes, Gray coded in order normal, dual, float, quad
	typedef enum logic [1:0] {
		FDM_MODE_NORMAL = 2'h0,
		FDM_MODE_DUAL = 2'h1,
		FDM_MODE_FLOAT = 2'h3,
		FDM_MODE_QUAD = 2'h2
	} fdm_mode_e;

	// what the adder stage does with the product
	typedef enum logic [1:0] {
		FDM_OP_ADD = 2'h0,
		FDM_OP_SUB = 2'h1,
		FDM_OP_ACC = 2'h3
	} fdm_op_e;

	// control word as held in the control register
	typedef struct packed {
		logic [3:0] shamt;
		logic useAdder;
		logic [1:0] op;
		logic signedOps;
		logic [1:0] mode;
	} fdm_ctrl_s;

	// operands from the fabric
	typedef struct packed {
		logic [`FDM_A_W-1:0] a;
		logic [`FDM_B_W-1:0] b;
		logic [`FDM_RES_W-1:0] c;
	} fdm_opnd_s;

endpackage : fdm_pkg

// ==== fdm_dsp_block.sv ====
/*
 * Hardened multiply-add block: partitioned integer multiply with
 * add/subtract/accumulate, bfloat16 fused multiply-add and a 4-bit
 * variable right shifter, configured over a plain register port.
 * Assumes operands and opValid come from fabric logic on clk.
 */
// The implementer's own choices: strobed register access and the address map.
// Operation
// - multiply, add, subtract, accumulate, plus right shift by a 4-bit amount.
// - one mode of four; widest mode does 19x18 product, 48-bit adder.
// - dual mode: 11x10 and 8x8 products, each with a 24-bit adder.
// - quad mode: one 7x6 and three 4x4 products, four 12-bit lanes.
// - quad mode 7x6 lane result is truncated to 12 bits.
// - float mode does one bfloat16 fused multiply add, subtract or accumulate.
// - shifter is one lane normal, two lanes dual, four lanes quad.
// - integer multipliers are signed or unsigned per a configuration bit.
// - operands come from A and B; product may feed the adder stage.
`include "fdm_params.svh"

module fdm_dsp_block (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] busAddr,
	input wire logic [31:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	output logic [31:0] busRdata,
	input wire fdm_pkg::fdm_opnd_s operands,
	input wire logic opValid,
	output logic [`FDM_RES_W-1:0] result,
	output logic resValid
);
	import fdm_pkg::*;

	fdm_ctrl_s cfg_q, cfg_d;
	logic [`FDM_RES_W-1:0] res_q, res_d;
	logic resValid_q, resValid_d;
	logic [31:0] rdata_q, rdata_d;
	logic clrCmd;

	// sign or zero extend the low w bits of v to the full width
	function automatic logic [47:0] ext(input logic [47:0] v,
		input int w, input logic s);
		logic [47:0] r;
		r = v;
		for (int i = 0; i < 48; i++) begin
			if (i >= w) begin
				r[i] = s & v[w-1];
			end
		end
		return r;
	endfunction : ext

	// one multiplier of aw x bw bits; low 48 bits are exact in both signs
	function automatic logic [47:0] mul(input logic [47:0] a, input int aw,
		input logic [47:0] b, input int bw, input logic s);
		return ext(a, aw, s) * ext(b, bw, s);
	endfunction : mul

	// adder stage and shifter of one lane w bits wide
	function automatic logic [47:0] lane(input logic [47:0] p,
		input logic [47:0] c, input logic [47:0] acc, input int w,
		input fdm_ctrl_s k);
		logic [47:0] r;
		r = p;
		if (k.useAdder) begin
			unique case (k.op)
				FDM_OP_SUB: r = c - p;
				FDM_OP_ACC: r = acc + p;
				default: r = c + p;
			endcase
		end
		// re-extend so the shift sees the lane's own sign bit
		r = ext(r, w, k.signedOps);
		if (k.signedOps) begin
			r = $signed(r) >>> k.shamt;
		end else begin
			r = r >> k.shamt;
		end
		return ext(r, w, 1'b0);
	endfunction : lane

	// bfloat16 fused multiply-add; product kept unrounded, result truncated,
	// subnormals flushed to zero and no NaN propagation to keep it small
	function automatic logic [15:0] bf16MulAdd(input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] c);
		logic sp, sr;
		logic [15:0] mp;
		logic signed [11:0] ep, ec, er, en;
		logic [24:0] xp, xc, xs;
		int d, hb;
		mp = {|a[14:7], a[6:0]} * {|b[14:7], b[6:0]};
		sp = a[15] ^ b[15];
		ep = 12'(a[14:7]) + 12'(b[14:7]) - 12'sh07F;
		if (a[14:7] == 8'h00 || b[14:7] == 8'h00) begin
			mp = 16'h0000;
			ep = 12'sh000;
		end
		xp = {1'b0, mp, 8'h00};
		ec = 12'(c[14:7]);
		xc = (c[14:7] == 8'h00) ? 25'h0 : {2'b01, c[6:0], 16'h0000} >> 1;
		if (ep >= ec) begin
			d = int'(ep - ec);
			xc = (d > 24) ? 25'h0 : xc >> d;
			er = ep;
		end else begin
			d = int'(ec - ep);
			xp = (d > 24) ? 25'h0 : xp >> d;
			er = ec;
		end
		if (sp == c[15]) begin
			xs = xp + xc;
			sr = sp;
		end else if (xp >= xc) begin
			xs = xp - xc;
			sr = sp;
		end else begin
			xs = xc - xp;
			sr = c[15];
		end
		hb = 0;
		for (int i = 0; i < 25; i++) begin
			if (xs[i]) begin
				hb = i;
			end
		end
		en = er + 12'(hb) - 12'sh016;
		xs = xs << (24 - hb);
		if (xs == 25'h0 || en <= 12'sh000) begin
			return {sr, 15'h0000};
		end
		if (en >= 12'sh0FF) begin
			return {sr, 8'hFF, 7'h00};
		end
		return {sr, en[7:0], xs[23:17]};
	endfunction : bf16MulAdd

	// a clear command is a write of the clear bit to the command register
	assign clrCmd = busWr && busAddr == `FDM_OFS_CMD
		&& busWdata[`FDM_CMD_CLR_BIT];

	// register port: control writes and one-cycle read data
	always_comb begin
		cfg_d = cfg_q;
		rdata_d = 32'h0000_0000;
		if (busWr && busAddr == `FDM_OFS_CTRL) begin
			cfg_d = fdm_ctrl_s'(busWdata[`FDM_CTRL_W-1:0]);
		end
		if (busRd) begin
			unique case (busAddr)
				`FDM_OFS_CTRL: rdata_d = {22'h0, cfg_q};
				`FDM_OFS_RES_LO: rdata_d = res_q[31:0];
				`FDM_OFS_RES_HI: rdata_d = {16'h0000, res_q[47:32]};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// datapath: partition the multiplier by mode, result held for accumulation
	always_comb begin
		logic [47:0] a, b, c;
		a = 48'(operands.a);
		b = 48'(operands.b);
		c = operands.c;
		res_d = res_q;
		resValid_d = 1'b0;
		if (opValid) begin
			resValid_d = 1'b1;
			unique case (fdm_mode_e'(cfg_q.mode))
				FDM_MODE_NORMAL: begin
					res_d = lane(mul(a, 19, b, 18, cfg_q.signedOps),
						ext(c, 48, 1'b0), res_q, 48, cfg_q);
				end
				FDM_MODE_DUAL: begin
					res_d[23:0] = 24'(lane(mul(a, 11, b, 10, cfg_q.signedOps),
						ext(c, 24, cfg_q.signedOps),
						ext(48'(res_q[23:0]), 24, cfg_q.signedOps), 24,
						cfg_q));
					res_d[47:24] = 24'(lane(mul(a >> 11, 8, b >> 10, 8,
						cfg_q.signedOps), ext(c >> 24, 24, cfg_q.signedOps),
						ext(48'(res_q[47:24]), 24, cfg_q.signedOps), 24,
						cfg_q));
				end
				FDM_MODE_QUAD: begin
					// lane 0 is 7x6, lanes 1..3 are 4x4; every lane keeps 12 bits
					for (int k = 0; k < 4; k++) begin
						res_d[12*k +: 12] = 12'(lane(
							mul(a >> (k == 0 ? 0 : 3 + 4*k), k == 0 ? 7 : 4,
								b >> (k == 0 ? 0 : 2 + 4*k), k == 0 ? 6 : 4,
								cfg_q.signedOps),
							ext(c >> (12*k), 12, cfg_q.signedOps),
							ext(res_q >> (12*k), 12, cfg_q.signedOps), 12,
							cfg_q));
					end
				end
				FDM_MODE_FLOAT: begin
					unique case (cfg_q.op)
						FDM_OP_SUB: res_d = {32'h0, bf16MulAdd(a[15:0], b[15:0],
							{~c[15], c[14:0]})};
						FDM_OP_ACC: res_d = {32'h0, bf16MulAdd(a[15:0], b[15:0],
							res_q[15:0])};
						default: res_d = {32'h0, bf16MulAdd(a[15:0], b[15:0],
							cfg_q.useAdder ? c[15:0] : 16'h0000)};
					endcase
				end
			endcase
		end
		if (clrCmd) begin
			res_d = 48'h0;
		end
	end

	// all state registered here; reset leaves a zero running sum
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q <= fdm_ctrl_s'(`FDM_CTRL_RST);
			res_q <= 48'h0;
			resValid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			cfg_q <= cfg_d;
			res_q <= res_d;
			resValid_q <= resValid_d;
			rdata_q <= rdata_d;
		end
	end

	assign result = res_q;
	assign resValid = resValid_q;
	assign busRdata = rdata_q;

	// reference figures for the checks below
	logic [47:0] refProd;
	logic plainInt;
	assign refProd = 48'(operands.a) * 48'(operands.b);
	// signed reference: widen with sign first so the low 48 bits are exact
	logic [47:0] refSProd;
	assign refSProd = 48'($signed(operands.a)) * 48'($signed(operands.b));
	assign plainInt = opValid && !clrCmd && !cfg_q.signedOps;

	default clocking dflt @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	normal_product_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_NORMAL && !cfg_q.useAdder
		&& cfg_q.shamt == 4'h0 |=> result == $past(refProd))
		else $error("normal mode product wrong");
	normal_shift_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_NORMAL && !cfg_q.useAdder
		|=> result == ($past(refProd) >> $past(cfg_q.shamt)))
		else $error("shifted product wrong");
	normal_sub_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_NORMAL && cfg_q.useAdder
		&& cfg_q.op == FDM_OP_SUB && cfg_q.shamt == 4'h0
		|=> result == $past(operands.c) - $past(refProd))
		else $error("subtract stage wrong");
	accum_sum_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_NORMAL && cfg_q.useAdder
		&& cfg_q.op == FDM_OP_ACC && cfg_q.shamt == 4'h0
		|=> result == $past(result) + $past(refProd))
		else $error("accumulation wrong");
	dual_lane_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_DUAL && !cfg_q.useAdder
		&& cfg_q.shamt == 4'h0 |=> result[47:24]
		== 24'($past(operands.a[18:11])) * 24'($past(operands.b[17:10])))
		else $error("dual 8x8 lane wrong");
	dual_low_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_DUAL && !cfg_q.useAdder
		&& cfg_q.shamt == 4'h0 |=> result[23:0]
		== 24'($past(operands.a[10:0])) * 24'($past(operands.b[9:0])))
		else $error("dual 11x10 lane wrong");
	quad_trunc_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_QUAD && !cfg_q.useAdder
		&& cfg_q.shamt == 4'h0 |=> result[11:0]
		== 12'($past(operands.a[6:0])) * 12'($past(operands.b[5:0])))
		else $error("quad 7x6 lane wrong");
	quad_lane_a: assert property (
		plainInt && cfg_q.mode == FDM_MODE_QUAD && !cfg_q.useAdder
		&& cfg_q.shamt == 4'h0 |=> result[23:12]
		== 12'($past(operands.a[10:7])) * 12'($past(operands.b[9:6])))
		else $error("quad 4x4 lane wrong");
	signed_prod_a: assert property (
		opValid && !clrCmd && cfg_q.signedOps && !cfg_q.useAdder
		&& cfg_q.mode == FDM_MODE_NORMAL && cfg_q.shamt == 4'h0
		|=> result == $past(refSProd))
		else $error("signed product wrong");
	float_upper_a: assert property (
		opValid && !clrCmd && cfg_q.mode == FDM_MODE_FLOAT
		|=> result[47:16] == 32'h0)
		else $error("float upper bits not zero");
	result_valid_a: assert property (
		opValid |=> resValid)
		else $error("result valid missing");
	clear_zero_a: assert property (
		clrCmd |=> result == 48'h0 ##1 (!$past(opValid) -> result == 48'h0))
		else $error("clear did not zero result");
	idle_hold_a: assert property (
		!opValid && !clrCmd |=> $stable(result) && !resValid)
		else $error("result moved without enable");
	ctrl_read_a: assert property (
		busRd && busAddr == `FDM_OFS_CTRL |=> busRdata == {22'h0, $past(cfg_q)}
		##1 (!$past(busRd) -> busRdata == 32'h0))
		else $error("control readback wrong");
	// read data only stand in the cycle after a read strobe
	rdata_idle_a: assert property (
		!busRd |=> busRdata == 32'h0)
		else $error("read data outside read cycle");

endmodule : fdm_dsp_block

// ==== fdm_fabric_model.sv ====
/*
 * Fabric user logic that feeds operands and the enable to the block.
 * Assumes the caller starts each issue just after a rising clk edge.
 */
module fdm_fabric_model (
	input wire logic clk,
	output fdm_pkg::fdm_opnd_s operands,
	output logic opValid
);
	timeunit 1ns;
	timeprecision 1ps;
	import fdm_pkg::*;

	// idle at start: enable low, no operands offered
	initial begin
		operands = '0;
		opValid = 1'b0;
	end

	// n enabled cycles in a row; operands inverted once released so
	// stale values never pass for fresh ones
	task automatic issue(input fdm_opnd_s o, input int n);
		operands <= o;
		opValid <= 1'b1;
		repeat (n) @(posedge clk);
		opValid <= 1'b0;
		operands <= ~o;
	endtask : issue
endmodule : fdm_fabric_model

// ==== fdm_dsp_block_tb_top.sv ====
/*
 * Self-checking bench: register port tasks and datapath tests.
 * Assumes the fabric model drives operands and opValid.
 */
`include "fdm_params.svh"

module fdm_dsp_block_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fdm_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] busAddr = 4'h0;
	logic [31:0] busWdata = 32'h0;
	logic busWr = 1'b0;
	logic busRd = 1'b0;
	logic [31:0] busRdata;
	fdm_opnd_s operands;
	logic opValid;
	logic [47:0] result;
	logic resValid;
	logic [47:0] ev;
	logic [1:0] md [3] = '{FDM_MODE_NORMAL, FDM_MODE_DUAL, FDM_MODE_QUAD};
	fdm_opnd_s o = '{a: 19'h7FFFF, b: 18'h2ABFF, c: 48'hFFF00F0F1234};
	fdm_opnd_s oz = '{a: 19'h7FFFF, b: 18'h2ABFF, c: 48'h0};
	int errors = 0;
	int nCompared = 0;

	// 50 MHz
	always #10 clk = ~clk;

	fdm_fabric_model i_fab (.clk(clk), .operands(operands),
		.opValid(opValid));
	fdm_dsp_block i_dut (.clk(clk), .sys_rst(rst), .busAddr(busAddr),
		.busWdata(busWdata), .busWr(busWr), .busRd(busRd),
		.busRdata(busRdata), .operands(operands), .opValid(opValid),
		.result(result), .resValid(resValid));

	task automatic complete_run;
		$display("compared %0d mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic cmp(input string nm, input logic [47:0] e,
		input logic [47:0] s);
		nCompared++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask : cmp

	// idle cycle after the strobe so a following write never reassigns it
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		busAddr <= ad;
		busWdata <= d;
		busWr <= 1'b1;
		@(posedge clk);
		busWr <= 1'b0;
		@(posedge clk);
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] ad, input logic [31:0] e);
		busAddr <= ad;
		busRd <= 1'b1;
		@(posedge clk);
		busRd <= 1'b0;
		@(negedge clk);
		cmp("busRdata", 48'(e), 48'(busRdata));
		@(posedge clk);
	endtask : rd

	task automatic setCtl(input logic [1:0] m, input logic sg,
		input logic [1:0] op, input logic ua, input logic [3:0] sh);
		fdm_ctrl_s k;
		k = '{shamt: sh, useAdder: ua, op: op, signedOps: sg, mode: m};
		wr(`FDM_OFS_CTRL, 32'(k));
		rd(`FDM_OFS_CTRL, 32'(k));
	endtask : setCtl

	task automatic getRes(input logic [47:0] e);
		@(negedge clk);
		cmp("resValid", 48'h1, {47'h0, resValid});
		cmp("result", e, result);
		@(posedge clk);
	endtask : getRes

	task automatic run(input fdm_opnd_s p, input logic [47:0] e);
		i_fab.issue(p, 1);
		getRes(e);
	endtask : run

	// unsigned lanes: slice, multiply, add c, wrap to lane, shift
	function automatic logic [47:0] expInt(input logic [1:0] m,
		input fdm_opnd_s p, input logic [3:0] sh);
		int n, w, al, aw, bl, bw;
		logic [47:0] r, l;
		r = '0;
		n = (m == FDM_MODE_NORMAL) ? 1 : (m == FDM_MODE_DUAL) ? 2 : 4;
		w = 48 / n;
		for (int k = 0; k < n; k++) begin
			aw = (n == 1) ? 19 : (n == 2) ? (k ? 8 : 11) : (k ? 4 : 7);
			bw = (n == 1) ? 18 : (n == 2) ? (k ? 8 : 10) : (k ? 4 : 6);
			al = (n == 4 && k > 0) ? 4 * k + 3 : k * 11;
			bl = (n == 4 && k > 0) ? 4 * k + 2 : k * 10;
			l = ((48'(p.a) >> al) & ((48'h1 << aw) - 48'h1))
				* ((48'(p.b) >> bl) & ((48'h1 << bw) - 48'h1)) + (p.c >> (k * w));
			l = (l & ((48'h1 << w) - 48'h1)) >> sh;
			r = r | (l << (k * w));
		end
		return r;
	endfunction : expInt

	// watchdog: the tests need under two hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`FDM_OFS_CTRL, 32'h0);
		rd(`FDM_OFS_RES_HI, 32'h0);
		wr(4'h2, 32'hFFFFFFFF);
		rd(4'h2, 32'h0);
		$display("test reset done");
		// every integer mode, shift amounts up to the 4-bit maximum
		foreach (md[i]) begin
			for (int s = 0; s < 16; s += 5) begin
				setCtl(md[i], 1'b0, FDM_OP_ADD, 1'b1, 4'(s));
				run(o, expInt(md[i], o, 4'(s)));
			end
			// adder off: bare lane products
			setCtl(md[i], 1'b0, FDM_OP_ADD, 1'b0, 4'h0);
			run(oz, expInt(md[i], oz, 4'h0));
		end
		// product straight out, read back over the port
		ev = 48'(o.a) * 48'(o.b);
		setCtl(FDM_MODE_NORMAL, 1'b0, FDM_OP_ADD, 1'b0, 4'h0);
		run(o, ev);
		rd(`FDM_OFS_RES_LO, ev[31:0]);
		rd(`FDM_OFS_RES_HI, {16'h0, ev[47:32]});
		// unsigned subtract: c minus the product
		ev = o.c - 48'(o.a) * 48'(o.b);
		setCtl(FDM_MODE_NORMAL, 1'b0, FDM_OP_SUB, 1'b1, 4'h0);
		run(o, ev);
		$display("test integer done");
		setCtl(FDM_MODE_NORMAL, 1'b1, FDM_OP_ADD, 1'b0, 4'h0);
		run('{a: 19'h7FFFF, b: 18'h3, c: 48'hA}, 48'hFFFFFFFFFFFD);
		setCtl(FDM_MODE_NORMAL, 1'b1, FDM_OP_SUB, 1'b1, 4'h0);
		run('{a: 19'h7FFFF, b: 18'h3, c: 48'hA}, 48'hD);
		$display("test signed done");
		wr(`FDM_OFS_CMD, 32'h1);
		rd(`FDM_OFS_RES_LO, 32'h0);
		setCtl(FDM_MODE_NORMAL, 1'b0, FDM_OP_ACC, 1'b1, 4'h0);
		i_fab.issue('{a: 19'h3, b: 18'h5, c: 48'h0}, 3);
		getRes(48'h2D);
		$display("test accumulate done");
		setCtl(FDM_MODE_FLOAT, 1'b0, FDM_OP_ADD, 1'b1, 4'h0);
		run('{a: 19'h3F80, b: 18'h4000, c: 48'h3F80}, 48'h4040);
		setCtl(FDM_MODE_FLOAT, 1'b0, FDM_OP_SUB, 1'b1, 4'h0);
		run('{a: 19'h3F80, b: 18'h4000, c: 48'h3F80}, 48'h3F80);
		// accumulate onto the 1.0 left by the subtract: 1 + 1*2
		setCtl(FDM_MODE_FLOAT, 1'b0, FDM_OP_ACC, 1'b1, 4'h0);
		run('{a: 19'h3F80, b: 18'h4000, c: 48'h0}, 48'h4040);
		$display("test float done");
		complete_run();
	end
endmodule : fdm_dsp_block_tb_top
